// ==== include/pspc_cfg.svh ====
`ifndef PSPC_CFG_SVH
`define PSPC_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PSPC_OFF_VCO_PD_OVR 10'h1BE
`define PSPC_OFF_VCO_CAL 10'h1BF
`define PSPC_OFF_CAL_LOCK 10'h1C0
`define PSPC_OFF_CP_LVL 10'h1C1
`define PSPC_OFF_SDM_CTRL 10'h1C2
`define PSPC_OFF_SDM_SER 10'h1C3
`define PSPC_OFF_VAR_TRIM 10'h1C4
`define PSPC_OFF_VAR_REF 10'h1C5
`define PSPC_OFF_RECEIVER_MASTER_POWERDOWN 10'h200
`define PSPC_OFF_LANE_PD 10'h201
`define PSPC_OFF_SYNC_PD 10'h203
`define PSPC_OFF_RCV_RST 10'h206
// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define PSPC_WM_VCO_PD_OVR 8'h0F
`define PSPC_WM_VCO_CAL 8'hFF
`define PSPC_WM_CAL_LOCK 8'h3F
`define PSPC_WM_CP_LVL 8'h7F
`define PSPC_WM_SDM_CTRL 8'hCF
`define PSPC_WM_SDM_SER 8'h7F
`define PSPC_WM_VAR_TRIM 8'h7F
`define PSPC_WM_VAR_REF 8'h0F
`define PSPC_WM_RECEIVER_MASTER_POWERDOWN 8'h01
`define PSPC_WM_LANE_PD 8'hFF
`define PSPC_WM_SYNC_PD 8'h03
`define PSPC_WM_RCV_RST 8'h01
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSPC_RST_VCO_PD_OVR 8'h00
`define PSPC_RST_VCO_CAL 8'h8D
`define PSPC_RST_CAL_LOCK 8'h2E
`define PSPC_RST_CP_LVL 8'h15
`define PSPC_RST_SDM_CTRL 8'h80
`define PSPC_RST_SDM_SER 8'h00
`define PSPC_RST_VAR_TRIM 8'h33
`define PSPC_RST_VAR_REF 8'h08
`define PSPC_RST_RECEIVER_MASTER_POWERDOWN 8'h01
`define PSPC_RST_LANE_PD 8'h00
`define PSPC_RST_SYNC_PD 8'h00
`define PSPC_RST_RCV_RST 8'h01
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSPC_BIT_CAL_EN 7
`define PSPC_BIT_NEW_CAL 5
`define PSPC_BIT_CAL_DBL 4
`define PSPC_BIT_SYNC0_OFF 1
`define PSPC_BIT_SYNC1_OFF 0
`define PSPC_BIT_RECEIVER_MASTER_POWERDOWN 0
`define PSPC_BIT_RCV_RST 0
`define PSPC_LSB_ALC_WAIT 4
`define PSPC_LSB_CAL_CNT 2
`define PSPC_LSB_LOCK_CNT 2
`define PSPC_LSB_LOCK_MODE 0
`endif

// ==== include/pspc_pkg.sv ====
package pspc_pkg;
   typedef enum logic [3:0] {
      PSPC_VCO_PD_OVR, PSPC_VCO_CAL, PSPC_CAL_LOCK, PSPC_CP_LVL,
      PSPC_SDM_CTRL, PSPC_SDM_SER, PSPC_VAR_TRIM, PSPC_VAR_REF,
      PSPC_RECEIVER_MASTER_POWERDOWN, PSPC_LANE_PD, PSPC_SYNC_PD, PSPC_RCV_RST
   } pspc_reg_t;
   localparam int PSPC_NREG = 12;
   typedef struct packed {
      logic rx_master_powerdown;
      logic [7:0] lane_powerdown_vector;
      logic sync_out0_buffer_off;
      logic sync_out1_buffer_off;
      logic recovery_reset_low;
   } pspc_rx_ctrl_t;
   typedef struct packed {
      logic band_cal_en;
      logic [2:0] alc_wait;
      logic [1:0] cal_count_len;
      logic cal_count_double;
      logic use_new_cal;
      logic [1:0] lock_counter_length;
      logic [1:0] lock_mode;
   } pspc_pll_cal_t;
endpackage : pspc_pkg

// ==== rtl/pspc_regs.sv ====
`include "pspc_cfg.svh"
module pspc_regs
   import pspc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register access
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic addr_hit,
   // Decoded controls
   output pspc_rx_ctrl_t rx_ctrl,
   output pspc_pll_cal_t pll_cal,
   output logic band_cal_run,
   output logic cal_count_x2,
   // Raw trim and test registers
   output logic [7:0] vco_pd_ovr,
   output logic [7:0] cp_lvl_cfg,
   output logic [7:0] sdm_ctrl,
   output logic [7:0] sdm_ser,
   output logic [7:0] var_trim,
   output logic [7:0] var_ref
);
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Offset to valid flag and register index
   function automatic logic [4:0] dec(input logic [9:0] a);
      unique case (a)
         `PSPC_OFF_VCO_PD_OVR: dec = {1'b1, PSPC_VCO_PD_OVR};
         `PSPC_OFF_VCO_CAL: dec = {1'b1, PSPC_VCO_CAL};
         `PSPC_OFF_CAL_LOCK: dec = {1'b1, PSPC_CAL_LOCK};
         `PSPC_OFF_CP_LVL: dec = {1'b1, PSPC_CP_LVL};
         `PSPC_OFF_SDM_CTRL: dec = {1'b1, PSPC_SDM_CTRL};
         `PSPC_OFF_SDM_SER: dec = {1'b1, PSPC_SDM_SER};
         `PSPC_OFF_VAR_TRIM: dec = {1'b1, PSPC_VAR_TRIM};
         `PSPC_OFF_VAR_REF: dec = {1'b1, PSPC_VAR_REF};
         `PSPC_OFF_RECEIVER_MASTER_POWERDOWN: dec = {1'b1, PSPC_RECEIVER_MASTER_POWERDOWN};
         `PSPC_OFF_LANE_PD: dec = {1'b1, PSPC_LANE_PD};
         `PSPC_OFF_SYNC_PD: dec = {1'b1, PSPC_SYNC_PD};
         `PSPC_OFF_RCV_RST: dec = {1'b1, PSPC_RCV_RST};
         default: dec = 5'h00;
      endcase
   endfunction : dec

   // ----------------------------------------
   // Register table
   // ----------------------------------------
   // Bits that software may change, lowest register in the low byte
   localparam logic [PSPC_NREG*8-1:0] WMASK = {
      // Receiver power group
      `PSPC_WM_RCV_RST,
      `PSPC_WM_SYNC_PD,
      `PSPC_WM_LANE_PD,
      `PSPC_WM_RECEIVER_MASTER_POWERDOWN,
      // PLL test group
      `PSPC_WM_VAR_REF,
      `PSPC_WM_VAR_TRIM,
      `PSPC_WM_SDM_SER,
      `PSPC_WM_SDM_CTRL,
      `PSPC_WM_CP_LVL,
      `PSPC_WM_CAL_LOCK,
      `PSPC_WM_VCO_CAL,
      `PSPC_WM_VCO_PD_OVR
   };

   // Values loaded by reset, same order as the mask table
   localparam logic [PSPC_NREG*8-1:0] RSTV = {
      // Receiver power group
      `PSPC_RST_RCV_RST,
      `PSPC_RST_SYNC_PD,
      `PSPC_RST_LANE_PD,
      `PSPC_RST_RECEIVER_MASTER_POWERDOWN,
      // PLL test group
      `PSPC_RST_VAR_REF,
      `PSPC_RST_VAR_TRIM,
      `PSPC_RST_SDM_SER,
      `PSPC_RST_SDM_CTRL,
      `PSPC_RST_CP_LVL,
      `PSPC_RST_CAL_LOCK,
      `PSPC_RST_VCO_CAL,
      `PSPC_RST_VCO_PD_OVR
   };

   logic [4:0] sel;
   // Storage, one byte per mapped register
   logic [7:0] reg_q [PSPC_NREG];
   logic [7:0] reg_d [PSPC_NREG];
   logic [7:0] rd_word;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // True when the decoded offset selects register idx
   function automatic logic hit(input logic [4:0] s, input int idx);
      hit = s[4] && (s[3:0] == 4'(idx));
   endfunction : hit

   // Offset decode is shared by the write and read paths
   assign sel = dec(addr);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   // Reserved bits are cut off on the way in, so they always read back as zero
   genvar gi;
   generate
      for (gi = 0; gi < PSPC_NREG; gi++) begin : g_reg
         localparam logic [7:0] WM = WMASK[gi*8 +: 8];
         localparam logic [7:0] RV = RSTV[gi*8 +: 8];

         always_comb begin
            reg_d[gi] = reg_q[gi];
            if (wr_en && hit(sel, gi)) begin
               reg_d[gi] = wdata & WM;
            end
         end

         // Reset loads the power-on value of each register
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               reg_q[gi] <= RV;
            end else begin
               reg_q[gi] <= reg_d[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Unmapped offsets select nothing and read as zero
   always_comb begin
      rd_word = 8'h00;
      for (int i = 0; i < PSPC_NREG; i++) begin
         if (hit(sel, i)) begin
            rd_word = reg_q[i];
         end
      end
   end

   // A read in the cycle of a write to the same register returns the old value
   always_comb begin
      rdata_d = rdata_q;
      if (rd_en) begin
         rdata_d = rd_word;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Registered read data, held between reads
   assign rdata = rdata_q;
   // Flags an offset that maps to a register
   assign addr_hit = sel[4];

   // ----------------------------------------
   // Receiver power controls
   // ----------------------------------------
   always_comb begin
      rx_ctrl = '0;
      rx_ctrl.rx_master_powerdown = reg_q[PSPC_RECEIVER_MASTER_POWERDOWN][`PSPC_BIT_RECEIVER_MASTER_POWERDOWN];
      // One bit per lane, a set bit powers that lane down
      rx_ctrl.lane_powerdown_vector = reg_q[PSPC_LANE_PD];
      // Bit one serves sync output zero, bit zero sync output one
      rx_ctrl.sync_out0_buffer_off = reg_q[PSPC_SYNC_PD][`PSPC_BIT_SYNC0_OFF];
      rx_ctrl.sync_out1_buffer_off = reg_q[PSPC_SYNC_PD][`PSPC_BIT_SYNC1_OFF];
      // Active low: zero holds the lane recovery logic in reset
      rx_ctrl.recovery_reset_low = reg_q[PSPC_RCV_RST][`PSPC_BIT_RCV_RST];
   end

   // ----------------------------------------
   // PLL calibration controls
   // ----------------------------------------
   always_comb begin
      pll_cal = '0;
      pll_cal.band_cal_en = reg_q[PSPC_VCO_CAL][`PSPC_BIT_CAL_EN];
      pll_cal.alc_wait = reg_q[PSPC_VCO_CAL][`PSPC_LSB_ALC_WAIT +: 3];
      pll_cal.cal_count_len = reg_q[PSPC_VCO_CAL][`PSPC_LSB_CAL_CNT +: 2];
      // Reset selects the newer calibrator
      pll_cal.use_new_cal = reg_q[PSPC_CAL_LOCK][`PSPC_BIT_NEW_CAL];
      pll_cal.cal_count_double = reg_q[PSPC_CAL_LOCK][`PSPC_BIT_CAL_DBL];
      // Lock detector counter length and mode
      pll_cal.lock_counter_length = reg_q[PSPC_CAL_LOCK][`PSPC_LSB_LOCK_CNT +: 2];
      pll_cal.lock_mode = reg_q[PSPC_CAL_LOCK][`PSPC_LSB_LOCK_MODE +: 2];
   end

   // Calibration only runs while its enable bit is set
   assign band_cal_run = reg_q[PSPC_VCO_CAL][`PSPC_BIT_CAL_EN];
   // Doubling has no effect while the newer calibrator is selected
   assign cal_count_x2 = reg_q[PSPC_CAL_LOCK][`PSPC_BIT_CAL_DBL]
                         & ~reg_q[PSPC_CAL_LOCK][`PSPC_BIT_NEW_CAL];

   // ----------------------------------------
   // Trim and test registers
   // ----------------------------------------
   // Reserved bits are already zero in storage
   assign vco_pd_ovr = reg_q[PSPC_VCO_PD_OVR];
   assign cp_lvl_cfg = reg_q[PSPC_CP_LVL];
   assign sdm_ctrl = reg_q[PSPC_SDM_CTRL];
   assign sdm_ser = reg_q[PSPC_SDM_SER];
   assign var_trim = reg_q[PSPC_VAR_TRIM];
   assign var_ref = reg_q[PSPC_VAR_REF];
endmodule : pspc_regs

// ==== tb/pspc_regs_monitor.sv ====
module pspc_regs_monitor
   import pspc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire pspc_rx_ctrl_t rx_ctrl,
   input wire pspc_pll_cal_t pll_cal,
   input wire logic band_cal_run,
   input wire logic cal_count_x2
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Register to output relations
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_receiver_master_powerdown_wr: assert property (wr_en && addr == 10'h200 |=>
      rx_ctrl.rx_master_powerdown == $past(wdata[0])) else $error("receiver_master_powerdown");
   chk_lane_pd_wr: assert property (wr_en && addr == 10'h201 |=>
      rx_ctrl.lane_powerdown_vector == $past(wdata)) else $error("lane pd");
   chk_sync_bits_wr: assert property (wr_en && addr == 10'h203 |=>
      {rx_ctrl.sync_out0_buffer_off, rx_ctrl.sync_out1_buffer_off} == $past(wdata[1:0])) else $error("sync pd");
   chk_recov_rst_wr: assert property (wr_en && addr == 10'h206 |=>
      rx_ctrl.recovery_reset_low == $past(wdata[0])) else $error("recovery reset");
   chk_cal_double: assert property (cal_count_x2 == (pll_cal.cal_count_double && !pll_cal.use_new_cal))
      else $error("count double");
   chk_band_cal_run: assert property (band_cal_run == pll_cal.band_cal_en) else $error("band cal");
   chk_band_cal_wr: assert property (wr_en && addr == 10'h1BF |=>
      band_cal_run == $past(wdata[7])) else $error("band cal write");
   chk_lock_fields: assert property (wr_en && addr == 10'h1C0 |=>
      {pll_cal.lock_counter_length, pll_cal.lock_mode} == $past(wdata[3:0])) else $error("lock fields");
   chk_rsv_read: assert property (rd_en && addr == 10'h203 |=> rdata[7:2] == 6'h00) else $error("reserved");
   cover property (wr_en && addr == 10'h1C0);
   cover property (rd_en && addr == 10'h202);
   cover property (cal_count_x2);
endmodule : pspc_regs_monitor

bind pspc_regs pspc_regs_monitor i_mon(.mclk(mclk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
   .wdata(wdata), .rdata(rdata), .rx_ctrl(rx_ctrl), .pll_cal(pll_cal), .band_cal_run(band_cal_run),
   .cal_count_x2(cal_count_x2));

// ==== tb/pspc_regs_tb.sv ====
module pspc_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pspc_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   pspc_rx_ctrl_t rx_ctrl;
   pspc_pll_cal_t pll_cal;
   logic band_cal_run;
   logic cal_count_x2;
   logic addr_hit;
   logic [7:0] vco_pd_ovr;
   logic [7:0] cp_lvl_cfg;
   logic [7:0] sdm_ctrl;
   logic [7:0] sdm_ser;
   logic [7:0] var_trim;
   logic [7:0] var_ref;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   // Offset, writable mask, reset value
   logic [25:0] rows [12] = '{{10'h1BE, 8'h0F, 8'h00}, {10'h1BF, 8'hFF, 8'h8D}, {10'h1C0, 8'h3F, 8'h2E},
      {10'h1C1, 8'h7F, 8'h15}, {10'h1C2, 8'hCF, 8'h80}, {10'h1C3, 8'h7F, 8'h00}, {10'h1C4, 8'h7F, 8'h33},
      {10'h1C5, 8'h0F, 8'h08}, {10'h200, 8'h01, 8'h01}, {10'h201, 8'hFF, 8'h00}, {10'h203, 8'h03, 8'h00},
      {10'h206, 8'h01, 8'h01}};
   pspc_regs i_dut(.mclk(mclk), .rst_b(rst_b), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .rdata(rdata), .addr_hit(addr_hit), .rx_ctrl(rx_ctrl), .pll_cal(pll_cal), .band_cal_run(band_cal_run),
      .cal_count_x2(cal_count_x2), .vco_pd_ovr(vco_pd_ovr), .cp_lvl_cfg(cp_lvl_cfg), .sdm_ctrl(sdm_ctrl),
      .sdm_ser(sdm_ser), .var_trim(var_trim), .var_ref(var_ref));
   always #25 mclk = ~mclk;
   task print_verdict();
      if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input string n, input logic [11:0] s, input logic [11:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      @(negedge mclk);
   endtask : wr
   task rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(negedge mclk);
      chk("rdata", rdata, e);
   endtask : rd
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         wr(rows[i][25:16], 8'hFF);
         rd(rows[i][25:16], rows[i][15:8]);
      end
      chk("rx_ctrl", rx_ctrl, {1'b1, 8'hFF, 1'b1, 1'b1, 1'b1});
      chk("x2", cal_count_x2, 1'b0);
      chk("pll_cal", pll_cal, 12'hFFF);
      chk("addr_hit", addr_hit, 1'b1);
      chk("vco_pd_ovr", vco_pd_ovr, rows[0][15:8]);
      chk("cp_lvl_cfg", cp_lvl_cfg, rows[3][15:8]);
      chk("sdm_ctrl", sdm_ctrl, rows[4][15:8]);
      chk("sdm_ser", sdm_ser, rows[5][15:8]);
      chk("var_trim", var_trim, rows[6][15:8]);
      chk("var_ref", var_ref, rows[7][15:8]);
      wr(10'h1C0, 8'h10);
      chk("x2", cal_count_x2, 1'b1);
      chk("lock", {pll_cal.lock_counter_length, pll_cal.lock_mode}, 4'h0);
      wr(10'h1BF, 8'h00);
      chk("band", band_cal_run, 1'b0);
      wr(10'h203, 8'h02);
      wr(10'h206, 8'h00);
      chk("rx_ctrl", rx_ctrl, {1'b1, 8'hFF, 1'b1, 1'b0, 1'b0});
      wr(10'h200, 8'h00);
      chk("master", rx_ctrl.rx_master_powerdown, 1'b0);
      wr(10'h202, 8'hFF);
      rd(10'h202, 8'h00);
      chk("addr_hit", addr_hit, 1'b0);
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk("rx_ctrl", rx_ctrl, {1'b1, 8'h00, 1'b0, 1'b0, 1'b1});
      chk("pll_cal", pll_cal, 12'h8DE);
      chk("lock", {pll_cal.lock_counter_length, pll_cal.lock_mode}, 4'hE);
      chk("band", band_cal_run, 1'b1);
      for (int i = 0; i < 12; i++) rd(rows[i][25:16], rows[i][7:0]);
      print_verdict();
   end
endmodule : pspc_regs_tb
